// [design/dlpr_pkg.sv]
package dlpr_pkg;
	localparam int SET_WORDS = 8;
	localparam int NUM_SETS = 128;
	localparam int SET_IDX_W = 7;
	localparam int NUM_CHAN = 8;
	localparam int CHAN_W = 3;
	localparam int NUM_CODES = 64;
	localparam int CODE_W = 6;
	localparam int LINK_NULL = 16'hFFFF;
	localparam int LINK_BASE = 16'h4000;
	localparam int SET_BYTES_SH = 5;
	localparam int OPTIONS_IRQ_EN_BIT = 20;
	localparam int OPTIONS_CODE_LO = 12;
	localparam int WORD_OPTIONS = 0;
	localparam int WORD_SRC = 1;
	localparam int WORD_CNT = 2;
	localparam int WORD_DST = 3;
	localparam int WORD_BIDX = 4;
	localparam int WORD_LINK = 5;
	localparam int WORD_CIDX = 6;
	localparam int WORD_CCNT = 7;

	typedef struct packed {
		logic [31:0] ccnt;
		logic [31:0] cidx;
		logic [31:0] link_bcntrld;
		logic [31:0] bidx;
		logic [31:0] dst;
		logic [31:0] ab_cnt;
		logic [31:0] src;
		logic [31:0] channel_options_word;
	} dlpr_set_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic write;
	} dlpr_xfer_t;
endpackage

// [design/dlpr_engine.sv]
`timescale 1ns/1ps
// Operation
// - On set exhaustion with a link other than LINK_NULL, copy the linked set into the active set, continue unaided.
// - With completion_irq_enable set, flag completion using the options word's completion code.
// - Completion with completion_irq_enable set sets the pending flag indexed by the completion code; with it clear, no flag is set.
// - Pending flags stay set until software clears them; hardware never clears.
module dlpr_engine
	import dlpr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic [NUM_CHAN-1:0] event_in,
	input wire logic cfg_we_in,
	input wire logic [SET_IDX_W-1:0] cfg_set_in,
	input wire logic [2:0] cfg_word_in,
	input wire logic [31:0] cfg_data_in,
	input wire logic [NUM_CODES-1:0] pending_clear_in,
	input wire logic [31:0] rd_data_in,
	output logic [NUM_CODES-1:0] completion_pending_flags_out,
	output logic xfer_valid_out,
	output dlpr_xfer_t xfer_out,
	output logic [NUM_CHAN-1:0] busy_out
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WRITE = 4'h4,
		ST_RELOAD = 4'h8
	} dlpr_state_t;

	logic rst_s1, rst_n;
	logic [NUM_CHAN-1:0] ev_s1, ev_s2, ev_d;
	logic [NUM_CHAN-1:0] ev_pend;
	dlpr_set_t parameter_set_memory [NUM_SETS];
	dlpr_state_t state;
	logic [CHAN_W-1:0] chan;
	logic [15:0] byte_left;

	function automatic logic [SET_IDX_W-1:0] link_to_set(input logic [15:0] lk);
		logic [15:0] off;
		off = lk - 16'(LINK_BASE);
		return off[SET_IDX_W+SET_BYTES_SH-1:SET_BYTES_SH];
	endfunction

	always_ff @(posedge core_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end

	always_ff @(posedge core_clk_in or negedge rst_n)
		if (!rst_n)
		begin
			ev_s1 <= '0;
			ev_s2 <= '0;
			ev_d <= '0;
		end
		else
		begin
			ev_s1 <= event_in;
			ev_s2 <= ev_s1;
			ev_d <= ev_s2;
		end

	wire [NUM_CHAN-1:0] ev_rise = ev_s2 & ~ev_d;
	dlpr_set_t act;
	assign act = parameter_set_memory[SET_IDX_W'(chan)];
	wire [15:0] acnt = act.ab_cnt[15:0];
	wire [15:0] bcnt = act.ab_cnt[31:16];
	wire [15:0] link = act.link_bcntrld[15:0];
	wire last_elem = (byte_left == 16'h1);
	wire last_array = (bcnt <= 16'h1);
	wire set_done = last_elem && last_array;
	wire irq_en = act.channel_options_word[OPTIONS_IRQ_EN_BIT];
	wire [CODE_W-1:0] code = act.channel_options_word[OPTIONS_CODE_LO +: CODE_W];
	wire done_pulse = (state == ST_WRITE) && set_done;
	wire has_link = (link != 16'(LINK_NULL));
	wire [SET_IDX_W-1:0] link_set = link_to_set(link);
	wire [NUM_CODES-1:0] set_flags = (done_pulse && irq_en) ?
		(NUM_CODES'(1) << code) : '0;
	logic [NUM_CHAN-1:0] pick;
	logic [CHAN_W-1:0] pick_idx;
	always_comb
	begin
		pick = '0;
		pick_idx = '0;
		for (int i = NUM_CHAN - 1; i >= 0; i--)
			if (ev_pend[i])
				pick_idx = CHAN_W'(i);
		pick[pick_idx] = |ev_pend;
	end
	wire take = (state == ST_IDLE) && (|ev_pend);

	// Set beats clear so a completion landing on a clear is not lost
	always_ff @(posedge core_clk_in or negedge rst_n)
		if (!rst_n)
			completion_pending_flags_out <= '0;
		else
			completion_pending_flags_out <= (completion_pending_flags_out
				& ~pending_clear_in) | set_flags;

	always_ff @(posedge core_clk_in or negedge rst_n)
		if (!rst_n)
			ev_pend <= '0;
		else
			ev_pend <= (ev_pend & ~(take ? pick : '0)) | ev_rise;

	// Single element per event (A-sync); one engine serves channels in turn
	always_ff @(posedge core_clk_in or negedge rst_n)
		if (!rst_n)
		begin
			state <= ST_IDLE;
			chan <= '0;
			byte_left <= '0;
		end
		else
			unique case (state)
				ST_IDLE:
					if (take)
					begin
						chan <= pick_idx;
						state <= ST_READ;
					end
				ST_READ:
				begin
					byte_left <= bcnt;
					state <= ST_WRITE;
				end
				ST_WRITE:
					state <= (set_done && has_link) ? ST_RELOAD : ST_IDLE;
				ST_RELOAD:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase

	// Host writes share the port with engine updates; engine wins in its own cycle
	always_ff @(posedge core_clk_in)
		if (state == ST_RELOAD)
			parameter_set_memory[SET_IDX_W'(chan)] <= parameter_set_memory[link_set];
		else if (state == ST_WRITE)
		begin
			parameter_set_memory[SET_IDX_W'(chan)].ab_cnt[31:16] <= bcnt - 16'h1;
			parameter_set_memory[SET_IDX_W'(chan)].src <= act.src
				+ {{16{act.bidx[15]}}, act.bidx[15:0]};
			parameter_set_memory[SET_IDX_W'(chan)].dst <= act.dst
				+ {{16{act.bidx[31]}}, act.bidx[31:16]};
		end
		else if (cfg_we_in)
			case (cfg_word_in)
				3'(WORD_OPTIONS):
					parameter_set_memory[cfg_set_in].channel_options_word <= cfg_data_in;
				3'(WORD_SRC): parameter_set_memory[cfg_set_in].src <= cfg_data_in;
				3'(WORD_CNT): parameter_set_memory[cfg_set_in].ab_cnt <= cfg_data_in;
				3'(WORD_DST): parameter_set_memory[cfg_set_in].dst <= cfg_data_in;
				3'(WORD_BIDX): parameter_set_memory[cfg_set_in].bidx <= cfg_data_in;
				3'(WORD_LINK): parameter_set_memory[cfg_set_in].link_bcntrld <= cfg_data_in;
				3'(WORD_CIDX): parameter_set_memory[cfg_set_in].cidx <= cfg_data_in;
				default: parameter_set_memory[cfg_set_in].ccnt <= cfg_data_in;
			endcase

	always_ff @(posedge core_clk_in or negedge rst_n)
		if (!rst_n)
		begin
			xfer_valid_out <= 1'b0;
			xfer_out <= '0;
		end
		else if (state == ST_IDLE && take)
		begin
			xfer_valid_out <= 1'b1;
			xfer_out <= '{addr: parameter_set_memory[SET_IDX_W'(pick_idx)].src,
				data: 32'h0, write: 1'b0};
		end
		else if (state == ST_READ)
		begin
			xfer_valid_out <= 1'b1;
			xfer_out <= '{addr: act.dst, data: rd_data_in, write: 1'b1};
		end
		else
			xfer_valid_out <= 1'b0;

	always_comb
	begin
		busy_out = ev_pend;
		if (state != ST_IDLE)
			busy_out[chan] = 1'b1;
	end

	a_flag_sets: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(done_pulse && irq_en) |=> completion_pending_flags_out[$past(code)])
		else $error("completion did not set pending flag");
	a_flag_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(completion_pending_flags_out != 0 && pending_clear_in == 0)
		|=> ($past(completion_pending_flags_out) & ~completion_pending_flags_out) == 0)
		else $error("pending flag dropped without clear");
	// Other flags may already stand, so only newly raised bits count
	a_disabled_no_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(done_pulse && !irq_en) |=> (completion_pending_flags_out
		& ~$past(completion_pending_flags_out)) == 0)
		else $error("flag set with completion irq disabled");
	a_reload_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(done_pulse && has_link) |=> state == ST_RELOAD ##1 state == ST_IDLE)
		else $error("reload did not follow exhaustion");
	a_reload_copies: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		state == ST_RELOAD |=> act == $past(parameter_set_memory[link_set]))
		else $error("reload did not copy whole set");
	a_read_then_write: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(xfer_valid_out && !xfer_out.write) |=> (xfer_valid_out && xfer_out.write))
		else $error("read request not followed by write");
	c_reload: cover property (@(posedge core_clk_in) state == ST_RELOAD);
	c_flag: cover property (@(posedge core_clk_in) done_pulse && irq_en);
	c_set_clear: cover property (@(posedge core_clk_in) |(set_flags & pending_clear_in));
	c_no_irq: cover property (@(posedge core_clk_in) done_pulse && !irq_en);
	c_no_link: cover property (@(posedge core_clk_in) done_pulse && !has_link);
endmodule

// [tb/dlpr_mem_model.sv]
`timescale 1ns/1ps
module dlpr_mem_model
	import dlpr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic xfer_valid_in,
	input wire dlpr_xfer_t xfer_in,
	output logic [31:0] rd_data_out
);
	// Read data stands while the request stands; the engine takes it at the closing edge
	// Idle value toggles every clock so stale data never matches
	logic [31:0] stale;
	initial stale = 32'h0;
	always @(posedge core_clk_in)
		stale <= ~stale;
	assign rd_data_out = (xfer_valid_in && !xfer_in.write)
		? (xfer_in.addr ^ 32'h5A5A0000) : stale;
endmodule

// [tb/dlpr_engine_bench.sv]
`timescale 1ns/1ps
module dlpr_engine_bench
	import dlpr_pkg::*;
;
	localparam logic [31:0] SRC = 32'h01D00000;
	logic core_clk;
	logic reset_n;
	logic [7:0] ev;
	logic we;
	logic [6:0] set;
	logic [2:0] word;
	logic [31:0] data;
	logic [63:0] clr;
	logic [31:0] rd;
	logic [63:0] flags;
	logic xv;
	dlpr_xfer_t xf;
	logic [31:0] d;
	logic [7:0] busy;
	int mismatches;
	int checks;
	dlpr_engine dut_u (.core_clk_in(core_clk), .reset_n_in(reset_n), .event_in(ev),
		.cfg_we_in(we), .cfg_set_in(set), .cfg_word_in(word), .cfg_data_in(data),
		.pending_clear_in(clr), .rd_data_in(rd), .completion_pending_flags_out(flags),
		.xfer_valid_out(xv), .xfer_out(xf), .busy_out(busy));
	dlpr_mem_model mem_u (.core_clk_in(core_clk), .xfer_valid_in(xv), .xfer_in(xf),
		.rd_data_out(rd));
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [65:0] g, input logic [65:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Counts and buffer index are shared by ping and pong; options, destination and link are given per set
	task automatic wr_set(input logic [6:0] s, input logic [31:0] options, dst, link);
		logic [31:0] w [8];
		w = '{options, SRC, 32'h00020001, dst, 32'h00010000, link, 32'h0, 32'h1};
		for (int i = 0; i < 8; i++)
		begin
			@(negedge core_clk);
			we = 1;
			set = s;
			word = i[2:0];
			data = w[i];
		end
		@(negedge core_clk);
		we = 0;
	endtask
	// Event held until the element is served so only one rising edge is seen
	task automatic elem(input int c, input logic [31:0] dst);
		int n;
		@(negedge core_clk);
		ev[c] = 1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (xv !== 1'b1 && n < 20);
		chk({32'h0, xv, xf.write, xf.addr}, {32'h0, 1'b1, 1'b0, SRC});
		chk({58'h0, busy}, {58'h0, 8'h1 << c});
		@(posedge core_clk);
		#1;
		chk({xv, xf.write, xf.addr, xf.data}, {1'b1, 1'b1, dst, SRC ^ 32'h5A5A0000});
		@(negedge core_clk);
		ev[c] = 0;
		repeat (4) @(negedge core_clk);
		chk({58'h0, busy}, 66'h0);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		mismatches++;
		finish_test;
	end
	initial
	begin
		mismatches = 0;
		checks = 0;
		ev = 0;
		we = 0;
		set = 0;
		word = 0;
		data = 0;
		clr = 0;
		reset_n = 0;
		repeat (10) @(negedge core_clk);
		reset_n = 1;
		repeat (3) @(negedge core_clk);
		wr_set(7'd3, 32'h00103000, 32'h10800000, 32'h00024800);
		wr_set(7'd64, 32'h00103000, 32'h10800800, 32'h00024820);
		wr_set(7'd65, 32'h00103000, 32'h10800000, 32'h00024800);
		wr_set(7'd0, 32'h00005000, 32'h20000000, 32'h0000FFFF);
		for (int b = 0; b < 3; b++)
		begin
			d = (b == 1) ? 32'h10800800 : 32'h10800000;
			elem(3, d);
			chk({2'b0, flags}, (b == 1) ? 66'h8 : 66'h0);
			elem(3, d + 32'h1);
			chk({2'b0, flags}, 66'h8);
			if (b == 1)
			begin
				@(negedge core_clk);
				clr[3] = 1;
				@(negedge core_clk);
				clr = 0;
			end
		end
		$display("test ping_pong done");
		elem(0, 32'h20000000);
		elem(0, 32'h20000001);
		chk({2'b0, flags}, 66'h8);
		$display("test no_irq done");
		finish_test;
	end
endmodule
